// ==== rtl/tocc_pkg.sv ====
package tocc_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] TOCC_CH_A_CONTROL_OFFS = 8'h53;
  localparam logic [7:0] TOCC_CH_B_CONTROL_OFFS = 8'h54;
  localparam logic [7:0] TOCC_CH_A_CODE_OFFS = 8'h5b;
  localparam logic [7:0] TOCC_CH_B_CODE_OFFS = 8'h5c;
  localparam logic [7:0] TOCC_CH_A_UPPER_OFFS = 8'h63;
  localparam logic [7:0] TOCC_CH_B_UPPER_OFFS = 8'h64;
  localparam logic [7:0] TOCC_CH_A_LOWER_OFFS = 8'h6b;
  localparam logic [7:0] TOCC_CH_B_LOWER_OFFS = 8'h6c;
  localparam logic [7:0] TOCC_CH_A_STATUS_OFFS = 8'h70;
  localparam logic [7:0] TOCC_CH_B_STATUS_OFFS = 8'h71;
  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int TOCC_ENABLE_BIT = 2;
  localparam int TOCC_CENTRE_MSB = 1;
  localparam logic [7:0] TOCC_CONTROL_MASK = 8'h07;
  localparam logic [7:0] TOCC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TOCC_CODE_RESET = 8'h7f;
  localparam logic [7:0] TOCC_UPPER_RESET = 8'hff;
  localparam logic [7:0] TOCC_LOWER_RESET = 8'h00;
  localparam logic [7:0] TOCC_MIDCODE = 8'h7f;
  localparam int TOCC_ST_ACTIVE_BIT = 0;
  localparam int TOCC_ST_FAULT_BIT = 1;
  localparam int TOCC_ST_CLAMP_BIT = 2;
  // Centre levels: 00 -> 1.25 V, 01 -> 1.0 V, 10 -> 0.8 V, 11 -> 0.6 V.
  typedef enum logic [1:0] {
    TOCC_CENTRE_1V25,
    TOCC_CENTRE_1V00,
    TOCC_CENTRE_0V80,
    TOCC_CENTRE_0V60
  } tocc_centre_type;
endpackage

// ==== rtl/tocc_channel.sv ====
`timescale 1ns/10ps
`default_nettype none
module tocc_channel
  import tocc_pkg::*;
(
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [7:0] control_i, // Control register.
  input wire logic [7:0] code_i, // Programmed output code.
  input wire logic [7:0] upper_i, // Upper limit code.
  input wire logic [7:0] lower_i, // Lower limit code.
  output logic active_o, // Trim output active.
  output logic fault_o, // Lower limit above upper limit.
  output logic clamped_o, // Code was clamped.
  output logic [7:0] code_o, // Effective output code.
  output logic [1:0] centre_o // Centre level select.
);
  logic fault_next;
  logic [7:0] eff_next;

  assign fault_next = lower_i > upper_i;

  always_comb begin
    if (code_i > upper_i) begin
      eff_next = upper_i;
    end else if (code_i < lower_i) begin
      eff_next = lower_i;
    end else begin
      eff_next = code_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
      fault_o <= 1'b0;
      clamped_o <= 1'b0;
      code_o <= TOCC_CODE_RESET;
      centre_o <= 2'h0;
    end else begin
      active_o <= control_i[TOCC_ENABLE_BIT] && !fault_next;
      fault_o <= fault_next;
      clamped_o <= eff_next != code_i;
      code_o <= eff_next;
      centre_o <= control_i[TOCC_CENTRE_MSB:0];
    end
  end

  en_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (lower_i > upper_i) |=> !active_o)
    else $error("Channel active while lower limit exceeds upper limit.");
  en_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (control_i[TOCC_ENABLE_BIT] && lower_i <= upper_i) |=> active_o)
    else $error("Channel not active although enabled with sane limits.");
  upper_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (code_i > upper_i) |=> code_o == $past(upper_i))
    else $error("Code above upper limit not clamped.");
  lower_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (code_i <= upper_i && code_i < lower_i) |=> code_o == $past(lower_i))
    else $error("Code below lower limit not clamped.");
  centre_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> centre_o == $past(control_i[1:0]))
    else $error("Centre select does not follow control field.");
endmodule
`default_nettype wire

// ==== rtl/tocc_top.sv ====
// How it works
// - Control bit 2 enables the channel's trim output.
// - Control bits 1:0 pick centre level 1.25, 1.0, 0.8 or 0.6 V.
// - Each channel has a read/write 8-bit code; 0x7f is the centre.
// - A code above the upper limit is clamped to the upper limit.
// - A code below the lower limit and not above the upper limit is clamped to the lower limit.
// - Lower limit above upper limit keeps the channel output off.
`timescale 1ns/10ps
`default_nettype none
module tocc_top
  import tocc_pkg::*;
(
  input wire logic clk_i, // Clock, 250 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [7:0] addr_i, // Register address.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [7:0] rdata_o, // Read data, one cycle after the strobe.
  output logic [1:0] trim_output_enable_o, // Per channel output active.
  output logic [1:0] limit_fault_o, // Per channel limit fault.
  output logic [7:0] ch_a_output_code_bits_o, // Channel A effective code.
  output logic [7:0] ch_b_output_code_bits_o, // Channel B effective code.
  output logic [1:0] ch_a_centre_level_select_o, // Channel A centre level.
  output logic [1:0] ch_b_centre_level_select_o // Channel B centre level.
);
  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] control_reg [2];
  logic [7:0] code_reg [2];
  logic [7:0] upper_reg [2];
  logic [7:0] lower_reg [2];
  logic [1:0] active;
  logic [1:0] fault;
  logic [1:0] clamped;
  logic [7:0] eff_code [2];
  logic [1:0] centre [2];
  logic [7:0] rdata_next;

  // Builds the status byte of one channel, each flag at its own bit position.
  function automatic logic [7:0] status_byte(
    input logic act,
    input logic flt,
    input logic clp
  );
    status_byte = 8'h00;
    status_byte[TOCC_ST_ACTIVE_BIT] = act;
    status_byte[TOCC_ST_FAULT_BIT] = flt;
    status_byte[TOCC_ST_CLAMP_BIT] = clp;
  endfunction

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        control_reg[i] <= TOCC_CONTROL_RESET;
      end
    end else if (wr_i) begin
      if (addr_i == TOCC_CH_A_CONTROL_OFFS) begin
        control_reg[0] <= wdata_i & TOCC_CONTROL_MASK;
      end
      if (addr_i == TOCC_CH_B_CONTROL_OFFS) begin
        control_reg[1] <= wdata_i & TOCC_CONTROL_MASK;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        code_reg[i] <= TOCC_CODE_RESET;
        upper_reg[i] <= TOCC_UPPER_RESET;
        lower_reg[i] <= TOCC_LOWER_RESET;
      end
    end else if (wr_i) begin
      case (addr_i)
        TOCC_CH_A_CODE_OFFS: code_reg[0] <= wdata_i;
        TOCC_CH_B_CODE_OFFS: code_reg[1] <= wdata_i;
        TOCC_CH_A_UPPER_OFFS: upper_reg[0] <= wdata_i;
        TOCC_CH_B_UPPER_OFFS: upper_reg[1] <= wdata_i;
        TOCC_CH_A_LOWER_OFFS: lower_reg[0] <= wdata_i;
        TOCC_CH_B_LOWER_OFFS: lower_reg[1] <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    case (addr_i)
      TOCC_CH_A_CONTROL_OFFS: rdata_next = control_reg[0];
      TOCC_CH_B_CONTROL_OFFS: rdata_next = control_reg[1];
      TOCC_CH_A_CODE_OFFS: rdata_next = code_reg[0];
      TOCC_CH_B_CODE_OFFS: rdata_next = code_reg[1];
      TOCC_CH_A_UPPER_OFFS: rdata_next = upper_reg[0];
      TOCC_CH_B_UPPER_OFFS: rdata_next = upper_reg[1];
      TOCC_CH_A_LOWER_OFFS: rdata_next = lower_reg[0];
      TOCC_CH_B_LOWER_OFFS: rdata_next = lower_reg[1];
      TOCC_CH_A_STATUS_OFFS: rdata_next = status_byte(active[0], fault[0], clamped[0]);
      TOCC_CH_B_STATUS_OFFS: rdata_next = status_byte(active[1], fault[1], clamped[1]);
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stand for one cycle only, so a stale answer is never taken for a new one.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    tocc_channel u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .control_i(control_reg[g]),
      .code_i(code_reg[g]),
      .upper_i(upper_reg[g]),
      .lower_i(lower_reg[g]),
      .active_o(active[g]),
      .fault_o(fault[g]),
      .clamped_o(clamped[g]),
      .code_o(eff_code[g]),
      .centre_o(centre[g])
    );
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign trim_output_enable_o = active;
  assign limit_fault_o = fault;
  assign ch_a_output_code_bits_o = eff_code[0];
  assign ch_b_output_code_bits_o = eff_code[1];
  assign ch_a_centre_level_select_o = centre[0];
  assign ch_b_centre_level_select_o = centre[1];

  // ----------------------------------------------------------------------
  // Bus sequences
  // ----------------------------------------------------------------------
  sequence code_a_write_s;
    wr_i && addr_i == TOCC_CH_A_CODE_OFFS;
  endsequence
  sequence code_a_read_s;
    rd_i && addr_i == TOCC_CH_A_CODE_OFFS;
  endsequence
  sequence code_b_write_s;
    wr_i && addr_i == TOCC_CH_B_CODE_OFFS;
  endsequence
  sequence code_b_read_s;
    rd_i && addr_i == TOCC_CH_B_CODE_OFFS;
  endsequence
  // An enable write only counts while the limits already allow the output.
  sequence enable_a_write_s;
    wr_i && addr_i == TOCC_CH_A_CONTROL_OFFS && wdata_i[TOCC_ENABLE_BIT]
      && lower_reg[0] <= upper_reg[0];
  endsequence
  sequence enable_b_write_s;
    wr_i && addr_i == TOCC_CH_B_CONTROL_OFFS && wdata_i[TOCC_ENABLE_BIT]
      && lower_reg[1] <= upper_reg[1];
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  ctrl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == TOCC_CH_A_CONTROL_OFFS) |=> rdata_o[7:3] == 5'h00)
    else $error("Unused control bits read as nonzero.");
  ctrl_b_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == TOCC_CH_B_CONTROL_OFFS) |=> rdata_o[7:3] == 5'h00)
    else $error("Unused control bits of channel B read as nonzero.");
  ctrl_a_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == TOCC_CH_A_CONTROL_OFFS)
    |=> control_reg[0] == {5'h00, $past(wdata_i[2:0])})
    else $error("Control write of channel A not masked.");
  ctrl_b_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == TOCC_CH_B_CONTROL_OFFS)
    |=> control_reg[1] == {5'h00, $past(wdata_i[2:0])})
    else $error("Control write of channel B not masked.");
  code_rw_a: assert property (@(posedge clk_i) disable iff (rst_i)
    code_a_write_s ##1 code_a_read_s |=> rdata_o == $past(wdata_i, 2))
    else $error("Code register read back differs from write.");
  code_b_rw_a: assert property (@(posedge clk_i) disable iff (rst_i)
    code_b_write_s ##1 code_b_read_s |=> rdata_o == $past(wdata_i, 2))
    else $error("Channel B code register read back differs from write.");
  en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    enable_a_write_s |=> ##1 trim_output_enable_o[0])
    else $error("Enable write did not activate channel A in two cycles.");
  en_b_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    enable_b_write_s |=> ##1 trim_output_enable_o[1])
    else $error("Enable write did not activate channel B in two cycles.");
  upper_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == TOCC_CH_A_UPPER_OFFS) |=> upper_reg[0] == $past(wdata_i))
    else $error("Upper limit write of channel A lost.");
  lower_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == TOCC_CH_A_LOWER_OFFS) |=> lower_reg[0] == $past(wdata_i))
    else $error("Lower limit write of channel A lost.");
  fault_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (lower_reg[0] > upper_reg[0]) |=> limit_fault_o[0])
    else $error("Channel A limit fault not flagged.");
  fault_b_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (lower_reg[1] > upper_reg[1]) |=> limit_fault_o[1])
    else $error("Channel B limit fault not flagged.");
  fault_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (limit_fault_o & trim_output_enable_o) == 2'b00)
    else $error("Channel output active during a limit fault.");
  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == TOCC_CH_A_STATUS_OFFS)
    |=> rdata_o[TOCC_ST_FAULT_BIT] == $past(limit_fault_o[0])
      && rdata_o[TOCC_ST_ACTIVE_BIT] == $past(trim_output_enable_o[0]))
    else $error("Status of channel A differs from its outputs.");
  status_b_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == TOCC_CH_B_STATUS_OFFS)
    |=> rdata_o[TOCC_ST_FAULT_BIT] == $past(limit_fault_o[1])
      && rdata_o[TOCC_ST_ACTIVE_BIT] == $past(trim_output_enable_o[1]))
    else $error("Status of channel B differs from its outputs.");
endmodule
`default_nettype wire

// ==== verif/tocc_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tocc_top_test;
  import tocc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [1:0] trim_output_enable_o;
  logic [1:0] limit_fault_o;
  logic [7:0] ch_a_output_code_bits_o;
  logic [7:0] ch_b_output_code_bits_o;
  logic [1:0] ch_a_centre_level_select_o;
  logic [1:0] ch_b_centre_level_select_o;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [7:0] r, c, u, l, e;

  tocc_top dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .trim_output_enable_o(trim_output_enable_o),
    .limit_fault_o(limit_fault_o),
    .ch_a_output_code_bits_o(ch_a_output_code_bits_o),
    .ch_b_output_code_bits_o(ch_b_output_code_bits_o),
    .ch_a_centre_level_select_o(ch_a_centre_level_select_o),
    .ch_b_centre_level_select_o(ch_b_centre_level_select_o)
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    exp_q.push_back(x);
    @(posedge clk_i);
  endtask

  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask

  // Read data is due in the cycle after the strobe and is zero otherwise.
  always @(posedge clk_i) begin
    if (rd_d && exp_q.size() > 0) begin
      r = exp_q.pop_front();
      `CHK(rdata_o, r)
    end else if (!rst_i) begin
      `CHK(rdata_o, 8'h00)
    end
    rd_d <= rd_i;
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h661cda33));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(8'h00, 8'hff);
    rd(TOCC_CH_A_CONTROL_OFFS, 8'h00);
    rd(TOCC_CH_B_CONTROL_OFFS, 8'h00);
    rd(TOCC_CH_A_CODE_OFFS, TOCC_CODE_RESET);
    rd(TOCC_CH_A_UPPER_OFFS, TOCC_UPPER_RESET);
    rd(TOCC_CH_A_LOWER_OFFS, TOCC_LOWER_RESET);
    rd(8'h00, 8'h00);
    idle(2);
    `CHK(trim_output_enable_o, 2'b00)
    `CHK(ch_a_output_code_bits_o, TOCC_MIDCODE)
    `CHK(ch_b_output_code_bits_o, TOCC_MIDCODE)
    `CHK(limit_fault_o, 2'b00)
    for (int i = 0; i < 8; i++) begin
      c = 8'($urandom);
      c[2:0] = i[2:0];
      wr(TOCC_CH_A_CONTROL_OFFS, c);
      wr(TOCC_CH_B_CONTROL_OFFS, c ^ 8'h04);
      rd(TOCC_CH_A_CONTROL_OFFS, c & 8'h07);
      rd(TOCC_CH_B_CONTROL_OFFS, (c ^ 8'h04) & 8'h07);
      idle(2);
      `CHK(trim_output_enable_o, {~c[2], c[2]})
      `CHK(ch_a_centre_level_select_o, c[1:0])
      `CHK(ch_b_centre_level_select_o, c[1:0])
    end
    for (int i = 0; i < 24; i++) begin
      c = 8'($urandom);
      u = 8'($urandom);
      l = (i == 0) ? u : 8'($urandom);
      e = (c > u) ? u : ((c < l) ? l : c);
      wr(TOCC_CH_A_UPPER_OFFS, u);
      wr(TOCC_CH_A_LOWER_OFFS, l);
      wr(TOCC_CH_A_CODE_OFFS, c);
      rd(TOCC_CH_A_CODE_OFFS, c);
      wr(TOCC_CH_B_UPPER_OFFS, u);
      wr(TOCC_CH_B_LOWER_OFFS, l);
      wr(TOCC_CH_B_CODE_OFFS, c);
      rd(TOCC_CH_B_CODE_OFFS, c);
      rd(TOCC_CH_A_STATUS_OFFS, {5'h00, e != c, l > u, l <= u});
      rd(TOCC_CH_B_STATUS_OFFS, {5'h00, e != c, l > u, 1'b0});
      idle(2);
      `CHK(limit_fault_o, {l > u, l > u})
      `CHK(trim_output_enable_o, {1'b0, l <= u})
      `CHK(ch_a_output_code_bits_o, e)
      `CHK(ch_b_output_code_bits_o, e)
    end
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(1);
    rd(TOCC_CH_A_CONTROL_OFFS, TOCC_CONTROL_RESET);
    rd(TOCC_CH_A_CODE_OFFS, TOCC_CODE_RESET);
    idle(2);
    `CHK(trim_output_enable_o, 2'b00)
    `CHK(ch_b_output_code_bits_o, TOCC_MIDCODE)
    idle(1);
    stop_test();
  end

  initial begin
    repeat (2000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
endmodule
`undef CHK
`default_nettype wire
